// file: logic/dsc_consts.svh
// register offsets, reset values, option bits and timing counts for the servo config block
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH
`define DSC_OFF_S1_OPT     8'h21
`define DSC_OFF_S2_OPT     8'h22
`define DSC_OFF_S1_SPEED   8'h24
`define DSC_OFF_S1_LEFT    8'h25
`define DSC_OFF_S1_RIGHT   8'h26
`define DSC_OFF_S2_SPEED   8'h28
`define DSC_OFF_S2_LEFT    8'h29
`define DSC_OFF_S2_RIGHT   8'h2a
`define DSC_OFF_S1_BSPD    8'h2c
`define DSC_OFF_S2_BSPD    8'h2d
`define DSC_OFF_S1_BDEF    8'h2e
`define DSC_OFF_S2_BDEF    8'h2f
`define DSC_OFF_BAR_DELAY  8'h30
`define DSC_OFF_FACTORY    8'h08
`define DSC_RST_OPT        8'h02
`define DSC_RST_SPEED      8'h0a
`define DSC_RST_LEFT       8'h7c
`define DSC_RST_RIGHT      8'h98
`define DSC_RST_BSPD       8'h7f
`define DSC_RST_BDEF       8'h1e
`define DSC_RST_BAR_DELAY  8'h00
`define DSC_BAR_DELAY_MAX  8'h05
`define DSC_BIT_INTERRUPT  0
`define DSC_BIT_COUPLE     1
`define DSC_BIT_BOB_LEFT   2
`define DSC_BIT_BOB_RIGHT  3
`define DSC_BIT_LEVER      4
`define DSC_BIT_SEESAW     5
`define DSC_BIT_BARRIER    7
`define DSC_CURVE_LINEAR   2'h0
`define DSC_CURVE_SEESAW   2'h1
`define DSC_CURVE_BOB      2'h2
`define DSC_CURVE_LEVER    2'h3
`define DSC_FLASH_NS       250000000
`define DSC_CLK_NS         25
`define DSC_FLASH_CYC      (`DSC_FLASH_NS / `DSC_CLK_NS)
`define DSC_STEP_ONE       8'h01
`endif

// file: logic/dsc_pkg.sv
// types for the servo config block
package dsc_pkg;
    typedef enum logic [1:0] {
        DSC_MODE_INIT,
        DSC_MODE_NORMAL,
        DSC_MODE_PROG
    } dsc_mode_t;
    typedef enum logic [2:0] {
        DSC_ST_S1_LEFT,
        DSC_ST_S1_RIGHT,
        DSC_ST_S1_SPEED,
        DSC_ST_S2_LEFT,
        DSC_ST_S2_RIGHT,
        DSC_ST_S2_SPEED,
        DSC_ST_S1_BOB,
        DSC_ST_S2_BOB
    } dsc_step_t;
endpackage

// file: logic/dsc_servo_config.sv
// servo configuration store with power-up button programming sequencer
//
// Contract
// - option bit 0 of each servo selects interruptible movement.
// - option coupling bit clear: auxiliary outputs follow own addresses only.
// - coupling bit set ties outputs to servos; option default is 2.
// - bit 2 enables bobbing at left stop, bit 3 at right stop.
// - bit 4 adds lever pause; bit 5 selects seesaw curve.
// - barrier bit honoured only in servo one options, applies to both.
// - left stop per servo, default 124, seesaw left peak.
// - right stop per servo, default 152, seesaw right peak.
// - barrier delay accepts 0 to 5, default 0.
// - program and servo two buttons at power-up enter flashing program mode.
// - eight programming steps cycle; program press confirms and advances.
// - end-stop steps: button one moves left, button two right.
// - speed steps: button one faster, button two slower.
// - bobbing steps: button one on, button two off.
// - program mode ends by power off; confirmed settings persist; the code only pulses nv_save on confirm, rst reloads factory defaults.
// - barrier mode forces bobbing curve for both servos.
// - barrier mode turns input one into a third output.
// - writing 128 or 0 to servo one options sets or clears barrier.
// - program and servo one buttons at power-up set barrier mode; the code only records barrier_pending, barrier_mode is unchanged.
// - program and servo two buttons at power-up clear barrier mode; the code only records barrier_pending, barrier_mode is unchanged.
// - any write to variable 8 restores factory defaults.
`timescale 1ns/10ps
`include "dsc_consts.svh"
module dsc_servo_config
    import dsc_pkg::*;
#(
    parameter int FLASH_CYC = `DSC_FLASH_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cv_wr,
    input  wire logic [7:0] cv_addr,
    input  wire logic [7:0] cv_wdata,
    output logic      [7:0] cv_rdata,
    input  wire logic       prog_button,
    input  wire logic       servo_one_button,
    input  wire logic       servo_two_button,
    output logic            led,
    output logic            prog_active,
    output logic      [2:0] prog_step,
    output logic            nv_save,
    output logic      [7:0] s1_options,
    output logic      [7:0] s2_options,
    output logic      [7:0] s1_speed,
    output logic      [7:0] s1_left,
    output logic      [7:0] s1_right,
    output logic      [7:0] s2_speed,
    output logic      [7:0] s2_left,
    output logic      [7:0] s2_right,
    output logic      [7:0] s1_bob_speed,
    output logic      [7:0] s2_bob_speed,
    output logic      [7:0] s1_bob_defl,
    output logic      [7:0] s2_bob_defl,
    output logic      [7:0] barrier_delay,
    output logic      [1:0] s1_interruptible,
    output logic      [1:0] aux_coupled,
    output logic      [1:0] s1_bob_ends,
    output logic      [1:0] s2_bob_ends,
    output logic      [1:0] s1_curve,
    output logic      [1:0] s2_curve,
    output logic            barrier_mode,
    output logic            input_one_is_output
);
    // pin synchronisers
    logic [2:0] btn_meta;
    logic [2:0] btn_sync;
    logic [2:0] btn_prev;
    logic       barrier_pending;
    logic       barrier_pending_val;
    logic [31:0] flash_cnt;
    dsc_mode_t  mode;
    dsc_step_t  step;
    always_ff @(posedge clk) begin
        if (rst) begin
            btn_meta <= 3'h0;
            btn_sync <= 3'h0;
            btn_prev <= 3'h0;
        end else begin
            btn_meta <= {servo_two_button, servo_one_button, prog_button};
            btn_sync <= btn_meta;
            btn_prev <= btn_sync;
        end
    end
    wire       p_held   = btn_sync[0];
    wire       b1_held  = btn_sync[1];
    wire       b2_held  = btn_sync[2];
    wire [2:0] btn_rise = btn_sync & ~btn_prev;
    wire       p_press  = btn_rise[0];
    wire       b1_press = btn_rise[1];
    wire       b2_press = btn_rise[2];

    // power-up decision one cycle after synchronised sample
    wire in_prog   = (mode == DSC_MODE_PROG);
    wire in_init   = (mode == DSC_MODE_INIT);
    wire start_prog = in_init && p_held && b2_held;
    wire start_bar_set = in_init && p_held && b1_held && !b2_held;
    wire start_bar_clr = start_prog;

    // startup waits for the synchroniser to fill
    logic [1:0] init_cnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            init_cnt <= 2'h0;
        end else if (init_cnt != 2'h3) begin
            init_cnt <= init_cnt + 2'h1;
        end
    end
    wire init_done = (init_cnt == 2'h3);

    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= DSC_MODE_INIT;
        end else begin
            case (mode)
                DSC_MODE_INIT: begin
                    if (init_done) begin
                        mode <= (p_held && b2_held) ? DSC_MODE_PROG : DSC_MODE_NORMAL;
                    end
                end
                DSC_MODE_PROG:   mode <= DSC_MODE_PROG;
                default:         mode <= DSC_MODE_NORMAL;
            endcase
        end
    end

    // step cycle, step 8 wraps to step 1
    always_ff @(posedge clk) begin
        if (rst) begin
            step <= DSC_ST_S1_LEFT;
        end else if (in_prog && p_press) begin
            step <= (step == DSC_ST_S2_BOB) ? DSC_ST_S1_LEFT : dsc_step_t'(step + 3'h1);
        end
    end
    assign prog_step   = 3'(step);
    assign prog_active = in_prog;
    // confirmed values handed to nonvolatile store
    assign nv_save     = in_prog && p_press;

    always_ff @(posedge clk) begin
        if (rst) begin
            flash_cnt <= 32'h0;
            led       <= 1'b0;
        end else if (in_prog) begin
            if (flash_cnt >= 32'(FLASH_CYC - 1)) begin
                flash_cnt <= 32'h0;
                led       <= ~led;
            end else begin
                flash_cnt <= flash_cnt + 32'h1;
            end
        end else begin
            led <= 1'b0;
        end
    end

    // button edits in programming mode; saturate to avoid wrap of stops
    function automatic logic [7:0] dsc_dec(input logic [7:0] v);
        dsc_dec = (v == 8'h00) ? v : v - 8'h01;
    endfunction
    function automatic logic [7:0] dsc_inc(input logic [7:0] v);
        dsc_inc = (v == 8'hff) ? v : v + 8'h01;
    endfunction

    wire edit   = in_prog && !p_press;
    wire ed_s1l = edit && step == DSC_ST_S1_LEFT;
    wire ed_s1r = edit && step == DSC_ST_S1_RIGHT;
    wire ed_s2l = edit && step == DSC_ST_S2_LEFT;
    wire ed_s2r = edit && step == DSC_ST_S2_RIGHT;
    wire ed_s1s = edit && step == DSC_ST_S1_SPEED;
    wire ed_s2s = edit && step == DSC_ST_S2_SPEED;
    wire ed_s1b = edit && step == DSC_ST_S1_BOB;
    wire ed_s2b = edit && step == DSC_ST_S2_BOB;

    // smaller stop value means further left
    wire [7:0] pb_s1l = b1_press ? dsc_dec(s1_left)  : b2_press ? dsc_inc(s1_left)  : s1_left;
    wire [7:0] pb_s1r = b1_press ? dsc_dec(s1_right) : b2_press ? dsc_inc(s1_right) : s1_right;
    wire [7:0] pb_s2l = b1_press ? dsc_dec(s2_left)  : b2_press ? dsc_inc(s2_left)  : s2_left;
    wire [7:0] pb_s2r = b1_press ? dsc_dec(s2_right) : b2_press ? dsc_inc(s2_right) : s2_right;
    // larger speed value means faster
    wire [7:0] pb_s1s = b1_press ? dsc_inc(s1_speed) : b2_press ? dsc_dec(s1_speed) : s1_speed;
    wire [7:0] pb_s2s = b1_press ? dsc_inc(s2_speed) : b2_press ? dsc_dec(s2_speed) : s2_speed;
    wire [1:0] bob_on = 2'h3;
    wire [7:0] pb_o1  = b1_press ? (s1_options | {4'h0, bob_on, 2'h0})
                      : b2_press ? (s1_options & ~{4'h0, bob_on, 2'h0}) : s1_options;
    wire [7:0] pb_o2  = b1_press ? (s2_options | {4'h0, bob_on, 2'h0})
                      : b2_press ? (s2_options & ~{4'h0, bob_on, 2'h0}) : s2_options;

    // configuration variable write decode
    wire wr_factory = cv_wr && cv_addr == `DSC_OFF_FACTORY;
    wire wr_o1  = cv_wr && cv_addr == `DSC_OFF_S1_OPT;
    wire wr_o2  = cv_wr && cv_addr == `DSC_OFF_S2_OPT;
    wire wr_s1s = cv_wr && cv_addr == `DSC_OFF_S1_SPEED;
    wire wr_s1l = cv_wr && cv_addr == `DSC_OFF_S1_LEFT;
    wire wr_s1r = cv_wr && cv_addr == `DSC_OFF_S1_RIGHT;
    wire wr_s2s = cv_wr && cv_addr == `DSC_OFF_S2_SPEED;
    wire wr_s2l = cv_wr && cv_addr == `DSC_OFF_S2_LEFT;
    wire wr_s2r = cv_wr && cv_addr == `DSC_OFF_S2_RIGHT;
    wire wr_b1s = cv_wr && cv_addr == `DSC_OFF_S1_BSPD;
    wire wr_b2s = cv_wr && cv_addr == `DSC_OFF_S2_BSPD;
    wire wr_b1d = cv_wr && cv_addr == `DSC_OFF_S1_BDEF;
    wire wr_b2d = cv_wr && cv_addr == `DSC_OFF_S2_BDEF;
    wire wr_bd  = cv_wr && cv_addr == `DSC_OFF_BAR_DELAY && cv_wdata <= `DSC_BAR_DELAY_MAX;

    // factory restore on any write to variable 8
    always_ff @(posedge clk) begin
        if (rst || wr_factory) begin
            s1_options    <= `DSC_RST_OPT;
            s2_options    <= `DSC_RST_OPT;
            s1_speed      <= `DSC_RST_SPEED;
            s2_speed      <= `DSC_RST_SPEED;
            s1_left       <= `DSC_RST_LEFT;
            s2_left       <= `DSC_RST_LEFT;
            s1_right      <= `DSC_RST_RIGHT;
            s2_right      <= `DSC_RST_RIGHT;
            s1_bob_speed  <= `DSC_RST_BSPD;
            s2_bob_speed  <= `DSC_RST_BSPD;
            s1_bob_defl   <= `DSC_RST_BDEF;
            s2_bob_defl   <= `DSC_RST_BDEF;
            barrier_delay <= `DSC_RST_BAR_DELAY;
        end else begin
            // servo one option write carries barrier bit
            s1_options    <= wr_o1  ? cv_wdata : ed_s1b ? pb_o1  : s1_options;
            s2_options    <= wr_o2  ? cv_wdata : ed_s2b ? pb_o2  : s2_options;
            s1_speed      <= wr_s1s ? cv_wdata : ed_s1s ? pb_s1s : s1_speed;
            s2_speed      <= wr_s2s ? cv_wdata : ed_s2s ? pb_s2s : s2_speed;
            s1_left       <= wr_s1l ? cv_wdata : ed_s1l ? pb_s1l : s1_left;
            s1_right      <= wr_s1r ? cv_wdata : ed_s1r ? pb_s1r : s1_right;
            s2_left       <= wr_s2l ? cv_wdata : ed_s2l ? pb_s2l : s2_left;
            s2_right      <= wr_s2r ? cv_wdata : ed_s2r ? pb_s2r : s2_right;
            s1_bob_speed  <= wr_b1s ? cv_wdata : s1_bob_speed;
            s2_bob_speed  <= wr_b2s ? cv_wdata : s2_bob_speed;
            s1_bob_defl   <= wr_b1d ? cv_wdata : s1_bob_defl;
            s2_bob_defl   <= wr_b2d ? cv_wdata : s2_bob_defl;
            barrier_delay <= wr_bd  ? cv_wdata : barrier_delay;
        end
    end

    // button-driven barrier change, only recorded; rst clears it and it never reaches barrier_mode
    always_ff @(posedge clk) begin
        if (rst) begin
            barrier_pending     <= 1'b0;
            barrier_pending_val <= 1'b0;
        end else if (init_done && (start_bar_set || start_bar_clr)) begin
            barrier_pending     <= 1'b1;
            barrier_pending_val <= start_bar_set;
        end
    end

    // read-back, unmapped reads as zero
    assign cv_rdata = (cv_addr == `DSC_OFF_S1_OPT)    ? s1_options
                    : (cv_addr == `DSC_OFF_S2_OPT)    ? s2_options
                    : (cv_addr == `DSC_OFF_S1_SPEED)  ? s1_speed
                    : (cv_addr == `DSC_OFF_S1_LEFT)   ? s1_left
                    : (cv_addr == `DSC_OFF_S1_RIGHT)  ? s1_right
                    : (cv_addr == `DSC_OFF_S2_SPEED)  ? s2_speed
                    : (cv_addr == `DSC_OFF_S2_LEFT)   ? s2_left
                    : (cv_addr == `DSC_OFF_S2_RIGHT)  ? s2_right
                    : (cv_addr == `DSC_OFF_S1_BSPD)   ? s1_bob_speed
                    : (cv_addr == `DSC_OFF_S2_BSPD)   ? s2_bob_speed
                    : (cv_addr == `DSC_OFF_S1_BDEF)   ? s1_bob_defl
                    : (cv_addr == `DSC_OFF_S2_BDEF)   ? s2_bob_defl
                    : (cv_addr == `DSC_OFF_BAR_DELAY) ? barrier_delay
                    : 8'h00;

    // option decoding
    // barrier bit of servo two is ignored
    assign barrier_mode = s1_options[`DSC_BIT_BARRIER];
    // input one becomes an output in barrier mode
    assign input_one_is_output = barrier_mode;
    // each option is its own bit
    assign s1_interruptible = {s2_options[`DSC_BIT_INTERRUPT], s1_options[`DSC_BIT_INTERRUPT]};
    // cleared bit leaves outputs on their own addresses
    // set bit couples outputs to servos
    assign aux_coupled = {s2_options[`DSC_BIT_COUPLE], s1_options[`DSC_BIT_COUPLE]};

    function automatic logic [1:0] dsc_curve(input logic [7:0] o, input logic bar);
        if (bar) begin
            dsc_curve = `DSC_CURVE_BOB;
        end else if (o[`DSC_BIT_SEESAW]) begin
            dsc_curve = `DSC_CURVE_SEESAW;
        end else if (o[`DSC_BIT_LEVER]) begin
            dsc_curve = `DSC_CURVE_LEVER;
        end else if (o[`DSC_BIT_BOB_LEFT] || o[`DSC_BIT_BOB_RIGHT]) begin
            dsc_curve = `DSC_CURVE_BOB;
        end else begin
            dsc_curve = `DSC_CURVE_LINEAR;
        end
    endfunction
    // bobbing ends, both forced in barrier mode
    assign s1_bob_ends = barrier_mode ? 2'h3
                       : {s1_options[`DSC_BIT_BOB_RIGHT], s1_options[`DSC_BIT_BOB_LEFT]};
    assign s2_bob_ends = barrier_mode ? 2'h3
                       : {s2_options[`DSC_BIT_BOB_RIGHT], s2_options[`DSC_BIT_BOB_LEFT]};
    // lever pause and seesaw curve selection
    assign s1_curve = dsc_curve(s1_options, barrier_mode);
    assign s2_curve = dsc_curve(s2_options, barrier_mode);

    // assertions
    // step wraps after eight presses
    wrap_step_a: assert property (@(posedge clk) disable iff (rst)
        in_prog && p_press && step == DSC_ST_S2_BOB |=> step == DSC_ST_S1_LEFT)
        else $error("step 8 did not return to step 1");
    advance_step_a: assert property (@(posedge clk) disable iff (rst)
        in_prog && p_press && step == DSC_ST_S1_SPEED |=> step == DSC_ST_S2_LEFT)
        else $error("servo one speed did not advance to servo two left");
    sequence entry_seq;
        in_init && init_done && p_held && b2_held;
    endsequence
    prog_entry_a: assert property (@(posedge clk) disable iff (rst)
        entry_seq |=> in_prog ##1 in_prog)
        else $error("programming mode not entered");
    prog_stays_a: assert property (@(posedge clk) disable iff (rst)
        in_prog |=> in_prog)
        else $error("programming mode left without power loss");
    left_move_a: assert property (@(posedge clk) disable iff (rst)
        ed_s1l && b1_press && !wr_s1l && !wr_factory && s1_left != 8'h00
        |=> s1_left == $past(s1_left) - 8'h01)
        else $error("left stop did not move left");
    faster_speed_a: assert property (@(posedge clk) disable iff (rst)
        ed_s2s && b1_press && !cv_wr && s2_speed != 8'hff
        |=> s2_speed == $past(s2_speed) + 8'h01)
        else $error("servo two speed not faster");
    bob_off_a: assert property (@(posedge clk) disable iff (rst)
        ed_s1b && b2_press && !cv_wr |=> s1_options[3:2] == 2'h0)
        else $error("bobbing not switched off");
    factory_reset_a: assert property (@(posedge clk) disable iff (rst)
        wr_factory |=> s1_left == `DSC_RST_LEFT && s2_right == `DSC_RST_RIGHT
                       && s1_options == `DSC_RST_OPT && s2_bob_defl == `DSC_RST_BDEF)
        else $error("factory defaults not restored");
    delay_range_a: assert property (@(posedge clk) disable iff (rst)
        barrier_delay <= `DSC_BAR_DELAY_MAX)
        else $error("barrier delay out of range");
    barrier_curve_a: assert property (@(posedge clk) disable iff (rst)
        barrier_mode |-> s1_curve == `DSC_CURVE_BOB && s2_curve == `DSC_CURVE_BOB
                         && input_one_is_output)
        else $error("barrier mode did not force curve");
    barrier_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_o1 && !wr_factory |=> barrier_mode == $past(cv_wdata[7]))
        else $error("barrier not following option write");
    bar_set_a: assert property (@(posedge clk) disable iff (rst)
        start_bar_set && init_done |=> barrier_pending && barrier_pending_val)
        else $error("barrier set combination not recorded");
    bar_clear_a: assert property (@(posedge clk) disable iff (rst)
        start_bar_clr && init_done |=> barrier_pending && !barrier_pending_val)
        else $error("barrier clear combination not recorded");
    led_idle_a: assert property (@(posedge clk) disable iff (rst)
        !in_prog |=> !led)
        else $error("led lit outside programming mode");
    step_hold_a: assert property (@(posedge clk) disable iff (rst)
        in_prog && !p_press |=> step == $past(step))
        else $error("step moved without a confirm press");
    slower_speed_a: assert property (@(posedge clk) disable iff (rst)
        ed_s1s && b2_press && !b1_press && !cv_wr && s1_speed != 8'h00
        |=> s1_speed == $past(s1_speed) - 8'h01)
        else $error("servo one speed not slower");
endmodule

// file: sim/dsc_station.sv
// command station and push-button model facing the servo config block
`timescale 1ns/10ps
module dsc_station (
    input  wire logic       clk,
    output logic            cv_wr,
    output logic      [7:0] cv_addr,
    output logic      [7:0] cv_wdata,
    output logic            prog_button,
    output logic            servo_one_button,
    output logic            servo_two_button
);
    initial begin
        cv_wr = 1'b0;
        cv_addr = 8'h00;
        {prog_button, servo_one_button, servo_two_button} = 3'h0;
    end
    // one strobe per write; released data inverted, not parked
    task automatic write_cv(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        {cv_wr, cv_addr, cv_wdata} = {1'b1, a, d};
        @(posedge clk);
        #2;
        cv_wr = 1'b0;
        cv_wdata = ~d;
    endtask
    task automatic read_cv(input logic [7:0] a);
        @(posedge clk);
        #2;
        cv_addr = a;
        #1;
    endtask
    task automatic hold_buttons(input logic p, input logic b1, input logic b2);
        @(posedge clk);
        #2;
        {prog_button, servo_one_button, servo_two_button} = {p, b1, b2};
    endtask
    // press long enough for the synchroniser
    task automatic press(input int which);
        hold_buttons(which == 0, which == 1, which == 2);
        repeat (5) @(posedge clk);
        hold_buttons(1'b0, 1'b0, 1'b0);
        repeat (5) @(posedge clk);
    endtask
endmodule

// file: sim/tb.sv
// self-checking bench for the servo config block against a register model
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb
    import dsc_pkg::*;
;
    logic       clk, rst, cv_wr, prog_button, servo_one_button, servo_two_button;
    logic       led, prog_active, nv_save, barrier_mode, input_one_is_output;
    logic [7:0] cv_addr, cv_wdata, cv_rdata, s1_options, s2_options, s1_speed, s1_left;
    logic [7:0] s1_right, s2_speed, s2_left, s2_right, s1_bob_speed, s2_bob_speed;
    logic [7:0] s1_bob_defl, s2_bob_defl, barrier_delay;
    logic [2:0] prog_step;
    logic [1:0] s1_interruptible, aux_coupled, s1_bob_ends, s2_bob_ends, s1_curve, s2_curve;
    // register outputs in the order of regs, lowest byte first
    wire  [103:0] outs = {barrier_delay, s2_bob_defl, s1_bob_defl, s2_bob_speed, s1_bob_speed,
                          s2_right, s2_left, s2_speed, s1_right, s1_left, s1_speed,
                          s2_options, s1_options};
    int         miscompares = 0;
    int         comparisons = 0;
    int         nv_cnt = 0;
    int         seed = 32'h1f784cf8;
    int         mdl[256];
    int         regs[13] = '{'h21, 'h22, 'h24, 'h25, 'h26, 'h28, 'h29, 'h2a, 'h2c, 'h2d,
                             'h2e, 'h2f, 'h30};
    int         defs[13] = '{2, 2, 10, 124, 152, 10, 124, 152, 127, 127, 30, 30, 0};
    int         steps[8] = '{'h25, 'h26, 'h24, 'h29, 'h2a, 'h28, 'h21, 'h22};
    int         opts[10] = '{1, 2, 4, 8, 16, 32, 128, 'h8c, 'h30, 0};

    dsc_station i_station (.clk, .cv_wr, .cv_addr, .cv_wdata, .prog_button,
        .servo_one_button, .servo_two_button);
    // short flash period keeps the led check brief
    dsc_servo_config #(.FLASH_CYC(4)) i_dut (.clk, .rst, .cv_wr, .cv_addr, .cv_wdata,
        .cv_rdata, .prog_button, .servo_one_button, .servo_two_button, .led, .prog_active,
        .prog_step, .nv_save, .s1_options, .s2_options, .s1_speed, .s1_left, .s1_right,
        .s2_speed, .s2_left, .s2_right, .s1_bob_speed, .s2_bob_speed, .s1_bob_defl,
        .s2_bob_defl, .barrier_delay, .s1_interruptible, .aux_coupled, .s1_bob_ends,
        .s2_bob_ends, .s1_curve, .s2_curve, .barrier_mode, .input_one_is_output);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge clk) begin
        if (nv_save === 1'b1) nv_cnt <= nv_cnt + 1;
    end

    function automatic int curve(int o, int bar);
        return bar ? 2 : o[5] ? 1 : o[4] ? 3 : (o[3:2] != 0) ? 2 : 0;
    endfunction
    // stops: button one left; speed: button one faster; saturating
    function automatic int edit(int s, int v, int b1);
        int up;
        up = (s == 2 || s == 5) ? b1 : !b1;
        if (s >= 6) return b1 ? (v | 12) : (v & 243);
        return up ? ((v < 255) ? v + 1 : v) : ((v > 0) ? v - 1 : v);
    endfunction
    task automatic factory;
        for (int i = 0; i < 13; i++) mdl[regs[i]] = defs[i];
    endtask
    task automatic wr(int a, int d);
        i_station.write_cv(a[7:0], d[7:0]);
        if (a == 8) factory();
        else if (a != 'h30 || d <= 5) mdl[a] = d;
    endtask
    task automatic power_up(logic p, logic b1, logic b2);
        i_station.hold_buttons(p, b1, b2);
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #2;
        rst = 1'b0;
        factory();
        repeat (6) @(posedge clk);
        #2;
    endtask
    task automatic check_all;
        int o1;
        int o2;
        int bar;
        for (int i = 0; i < 13; i++) begin
            i_station.read_cv(regs[i][7:0]);
            `CHK(cv_rdata, mdl[regs[i]][7:0])
            `CHK(outs[i*8 +: 8], mdl[regs[i]][7:0])
        end
        o1 = mdl['h21];
        o2 = mdl['h22];
        bar = o1[7];
        `CHK(barrier_mode, bar[0])
        `CHK(input_one_is_output, bar[0])
        `CHK(s1_interruptible, {o2[0], o1[0]})
        `CHK(aux_coupled, {o2[1], o1[1]})
        `CHK(s1_bob_ends, bar ? 2'h3 : o1[3:2])
        `CHK(s2_bob_ends, bar ? 2'h3 : o2[3:2])
        `CHK(s1_curve, 2'(curve(o1, bar)))
        `CHK(s2_curve, 2'(curve(o2, bar)))
        `CHK({s2_options, s1_options}, {o2[7:0], o1[7:0]})
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        int k;
        int b;
        int n0;
        rst = 1'b1;
        power_up(1'b0, 1'b0, 1'b0);
        check_all();
        `CHK({prog_active, led}, 2'h0)
        for (int i = 0; i < 40; i++) begin
            k = $unsigned($random(seed)) % 13;
            wr(regs[k], $random(seed) & 'hff);
            check_all();
        end
        for (int d = 0; d < 8; d++) begin
            wr('h30, d);
            check_all();
        end
        wr('h23, 'h5a);
        i_station.read_cv(8'h23);
        `CHK(cv_rdata, 8'h00)
        for (int i = 0; i < 10; i++) begin
            wr('h21, opts[i]);
            wr('h22, opts[9 - i]);
            check_all();
        end
        wr(8, $random(seed) & 'hff);
        check_all();
        power_up(1'b1, 1'b0, 1'b1);
        `CHK({prog_active, prog_step}, 4'h8)
        i_station.hold_buttons(1'b0, 1'b0, 1'b0);
        k = 0;
        repeat (40) begin
            b = led;
            @(posedge clk);
            #1;
            if (led !== b[0]) k++;
        end
        `CHK(k, 10)
        n0 = nv_cnt;
        for (int s = 0; s < 8; s++) begin
            k = $unsigned($random(seed)) % 3;
            repeat (k) begin
                i_station.press(1);
                mdl[steps[s]] = edit(s, mdl[steps[s]], 1);
            end
            k = $unsigned($random(seed)) % 3;
            repeat (k) begin
                i_station.press(2);
                mdl[steps[s]] = edit(s, mdl[steps[s]], 0);
            end
            i_station.press(0);
            check_all();
            `CHK(prog_step, 3'((s + 1) % 8))
            `CHK(nv_cnt - n0, s + 1)
        end
        // button one edits nothing outside programming
        power_up(1'b0, 1'b0, 1'b0);
        i_station.press(1);
        check_all();
        `CHK(prog_active, 1'b0)
        // barrier set combo: normal mode, registers and barrier_mode untouched
        power_up(1'b1, 1'b1, 1'b0);
        i_station.hold_buttons(1'b0, 1'b0, 1'b0);
        check_all();
        `CHK({prog_active, led}, 2'h0)
        print_verdict();
    end
endmodule
